// ===== hw/async_serial_port.sv
// Asynchronous serial port with APB register slave and baud generator.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - Length bit picks seven or eight data bits.
// - Stop-count bit picks one or two stops.
// - Parity enable adds and checks parity bit.
// - Parity sense picks even or odd parity.
// - Receive enable gates reception of characters.
// - Line control resets to zero.
// - Buffer reads receive data, writes transmit data.
// - Completed reception loads buffer, raises ready.
// - Moving holding to shift sets transmit ready.
// - Error flags set on completion, never auto-cleared.
// - Flags clear only by writing one.
// - Buffer and ready update despite errors.
// - Parity mismatch sets parity error flag.
// - Unread buffer at completion sets overrun.
// - Low stop sample sets framing error.
// - Loopback feeds transmit output to receiver.
// - Forced parity fault corrupts looped parity.
// - Forced framing fault corrupts looped stop.
// - Start and stop framing, full duplex.
// - Baud counter overflow ticks, interrupts, reloads.
// - Clock select divides base by 2..16.
// - Mode bit connects baud ticks to port.
// - Sixteen baud ticks make one bit.
module async_serial_port (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             rx_ready_irq,
  output logic             tx_ready_irq,
  output logic             baud_tick_irq
);

  // ==========================================================================
  // Registers and wires
  async_serial_port_pkg::line_control_t line_ff;
  async_serial_port_pkg::baud_control_t baudc_ff;
  async_serial_port_pkg::test_control_t test_ff;
  async_serial_port_pkg::serial_state_t tx_st_ff, rx_st_ff;
  logic [7:0]  status_ff, bcnt_ff, brld_ff, rx_buf_ff, tx_hold_ff, tx_shift_ff, rx_shift_ff;
  logic [7:0]  nxt_status, rd_mux;
  logic [3:0]  pre_ff, tx_sub_ff, rx_sub_ff;
  logic [2:0]  tx_cnt_ff, rx_cnt_ff;
  logic        tx_full_ff, tx_out_ff, tx_par_ff, unread_ff, sync1_ff, sync2_ff, rx_prev_ff;
  logic        rx_par_ff, prdata_vld;
  logic        acc, wr, rd, pre_tick, ovf, tick, tx_load, rx_line, rx_done, rx_sample;
  logic        par_err, frm_err;
  logic [2:0]  tx_last, rx_last;
  logic [7:0]  wbyte, rx_word;
  logic [31:0] prdata_ff;

  function automatic logic hit(input logic [31:0] a, input logic [27:0] idx);
    hit = a[async_serial_port_pkg::DEC_MSB:async_serial_port_pkg::DEC_LSB] == idx[9:0];
  endfunction : hit

  function automatic logic odd_sum(input logic [7:0] d, input logic len7);
    odd_sum = ^(len7 ? {1'b0, d[6:0]} : d);
  endfunction : odd_sum

  // ==========================================================================
  // APB slave
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign wbyte   = pwdata[7:0];
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign prdata_vld = hit(paddr, async_serial_port_pkg::IDX_DATA)
                   | hit(paddr, async_serial_port_pkg::IDX_STATUS)
                   | hit(paddr, async_serial_port_pkg::IDX_LINE)
                   | hit(paddr, async_serial_port_pkg::IDX_BAUDC)
                   | hit(paddr, async_serial_port_pkg::IDX_BCNT)
                   | hit(paddr, async_serial_port_pkg::IDX_BRLD)
                   | hit(paddr, async_serial_port_pkg::IDX_TEST);
  assign pslverr = acc & ~prdata_vld;

  always_comb begin
    rd_mux = 8'h00;
    if (hit(paddr, async_serial_port_pkg::IDX_DATA)) rd_mux = rx_buf_ff;
    if (hit(paddr, async_serial_port_pkg::IDX_STATUS)) rd_mux = status_ff;
    if (hit(paddr, async_serial_port_pkg::IDX_LINE)) rd_mux = line_ff;
    if (hit(paddr, async_serial_port_pkg::IDX_BAUDC)) rd_mux = baudc_ff;
    if (hit(paddr, async_serial_port_pkg::IDX_BCNT)) rd_mux = bcnt_ff;
    if (hit(paddr, async_serial_port_pkg::IDX_BRLD)) rd_mux = brld_ff;
    if (hit(paddr, async_serial_port_pkg::IDX_TEST)) rd_mux = test_ff;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_ff <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_ff <= async_serial_port_pkg::RST_LINE;
      test_ff <= async_serial_port_pkg::RST_TEST;
      brld_ff <= async_serial_port_pkg::RST_BRLD;
    end else if (wr) begin
      if (hit(paddr, async_serial_port_pkg::IDX_LINE)) line_ff <= wbyte;
      if (hit(paddr, async_serial_port_pkg::IDX_TEST)) test_ff <= wbyte;
      if (hit(paddr, async_serial_port_pkg::IDX_BRLD)) brld_ff <= wbyte;
    end
  end

  // ==========================================================================
  // Baud generator
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_ff <= 4'h0;
    end else if (baudc_ff.baud_run) begin
      pre_ff <= pre_ff + 4'h1;
    end
  end

  always_comb begin
    unique case (baudc_ff.baud_clock_select)
      2'h0: pre_tick = pre_ff[0];
      2'h1: pre_tick = &pre_ff[1:0];
      2'h2: pre_tick = &pre_ff[2:0];
      2'h3: pre_tick = &pre_ff;
    endcase
  end

  assign ovf  = baudc_ff.baud_run & pre_tick & (bcnt_ff == 8'hff);
  assign tick = ovf & baudc_ff.baud_mode_select;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bcnt_ff <= async_serial_port_pkg::RST_BCNT;
    end else if (wr & hit(paddr, async_serial_port_pkg::IDX_BCNT)) begin
      bcnt_ff <= wbyte;
    end else if (ovf) begin
      bcnt_ff <= brld_ff;
    end else if (baudc_ff.baud_run & pre_tick) begin
      bcnt_ff <= bcnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      baudc_ff <= async_serial_port_pkg::RST_BAUDC;
    end else begin
      if (wr & hit(paddr, async_serial_port_pkg::IDX_BAUDC)) begin
        baudc_ff <= (wbyte & ~(8'h01 << async_serial_port_pkg::BC_OVF))
                  | ({7'h00, baudc_ff.baud_overflow_flag & ~wbyte[async_serial_port_pkg::BC_OVF]}
                     << async_serial_port_pkg::BC_OVF);
      end
      if (ovf) baudc_ff.baud_overflow_flag <= 1'b1;
    end
  end

  assign baud_tick_irq = baudc_ff.baud_overflow_flag;

  // ==========================================================================
  // Transmitter
  assign tx_last = line_ff.char_length_sel ? async_serial_port_pkg::LAST_BIT7
                                           : async_serial_port_pkg::LAST_BIT8;
  assign tx_load = tick & tx_full_ff & (tx_st_ff == async_serial_port_pkg::S_IDLE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_full_ff <= 1'b0;
      tx_hold_ff <= 8'h00;
    end else if (wr & hit(paddr, async_serial_port_pkg::IDX_DATA)) begin
      tx_full_ff <= 1'b1;
      tx_hold_ff <= wbyte;
    end else if (tx_load) begin
      tx_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_st_ff    <= async_serial_port_pkg::S_IDLE;
      tx_sub_ff   <= 4'h0;
      tx_cnt_ff   <= 3'h0;
      tx_shift_ff <= 8'h00;
      tx_par_ff   <= 1'b0;
      tx_out_ff   <= 1'b1;
    end else if (tx_load) begin
      tx_st_ff    <= async_serial_port_pkg::S_START;
      tx_out_ff   <= 1'b0;
      tx_shift_ff <= tx_hold_ff;
      tx_sub_ff   <= 4'h0;
      tx_par_ff   <= odd_sum(tx_hold_ff, line_ff.char_length_sel) ^ ~line_ff.parity_sense;
    end else if (tick & (tx_st_ff != async_serial_port_pkg::S_IDLE)) begin
      tx_sub_ff <= tx_sub_ff + 4'h1;
      if (tx_sub_ff == async_serial_port_pkg::TICK_LAST) begin
        unique case (tx_st_ff)
          async_serial_port_pkg::S_START: begin
            tx_st_ff  <= async_serial_port_pkg::S_DATA;
            tx_cnt_ff <= 3'h0;
            tx_out_ff <= tx_shift_ff[0];
          end
          async_serial_port_pkg::S_DATA: begin
            tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
            tx_cnt_ff   <= tx_cnt_ff + 3'h1;
            tx_out_ff   <= tx_shift_ff[1];
            if (tx_cnt_ff == tx_last) begin
              tx_cnt_ff <= 3'h0;
              if (line_ff.parity_enable) begin
                tx_st_ff  <= async_serial_port_pkg::S_PAR;
                tx_out_ff <= tx_par_ff;
              end else begin
                tx_st_ff  <= async_serial_port_pkg::S_STOP;
                tx_out_ff <= 1'b1;
              end
            end
          end
          async_serial_port_pkg::S_PAR: begin
            tx_st_ff  <= async_serial_port_pkg::S_STOP;
            tx_out_ff <= 1'b1;
          end
          async_serial_port_pkg::S_STOP: begin
            tx_cnt_ff <= tx_cnt_ff + 3'h1;
            if (line_ff.tx_stop_count | (tx_cnt_ff != 3'h0)) begin
              tx_st_ff <= async_serial_port_pkg::S_IDLE;
            end
          end
          default: tx_st_ff <= async_serial_port_pkg::S_IDLE;
        endcase
      end
    end
  end

  assign serial_out_pin = tx_out_ff;

  // ==========================================================================
  // Receiver
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff   <= 1'b1;
      sync2_ff   <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      sync1_ff   <= serial_in_pin;
      sync2_ff   <= sync1_ff;
      rx_prev_ff <= rx_line;
    end
  end

  always_comb begin
    rx_line = sync2_ff;
    if (test_ff.loopback_enable) begin
      rx_line = tx_out_ff;
      if (test_ff.force_parity_fault & (rx_st_ff == async_serial_port_pkg::S_PAR)) begin
        rx_line = ~tx_out_ff;
      end
      if (test_ff.force_framing_fault & (rx_st_ff == async_serial_port_pkg::S_STOP)) begin
        rx_line = 1'b0;
      end
    end
  end

  assign rx_last   = line_ff.char_length_sel ? async_serial_port_pkg::LAST_BIT7
                                             : async_serial_port_pkg::LAST_BIT8;
  assign rx_sample = tick & (rx_sub_ff == async_serial_port_pkg::TICK_LAST);
  assign rx_done   = rx_sample & (rx_st_ff == async_serial_port_pkg::S_STOP);
  assign frm_err   = ~rx_line;
  assign rx_word   = line_ff.char_length_sel ? {1'b0, rx_shift_ff[7:1]} : rx_shift_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_st_ff    <= async_serial_port_pkg::S_IDLE;
      rx_sub_ff   <= 4'h0;
      rx_cnt_ff   <= 3'h0;
      rx_shift_ff <= 8'h00;
      rx_par_ff   <= 1'b0;
      par_err     <= 1'b0;
    end else if (rx_st_ff == async_serial_port_pkg::S_IDLE) begin
      rx_sub_ff <= 4'h0;
      par_err   <= 1'b0;
      if (line_ff.receive_enable & rx_prev_ff & ~rx_line) begin
        rx_st_ff <= async_serial_port_pkg::S_START;
      end
    end else if (tick) begin
      rx_sub_ff <= rx_sub_ff + 4'h1;
      if (rx_st_ff == async_serial_port_pkg::S_START) begin
        if (rx_sub_ff == async_serial_port_pkg::TICK_MID) begin
          rx_sub_ff <= 4'h0;
          rx_cnt_ff <= 3'h0;
          rx_par_ff <= 1'b0;
          rx_st_ff  <= rx_line ? async_serial_port_pkg::S_IDLE : async_serial_port_pkg::S_DATA;
        end
      end else if (rx_sample) begin
        unique case (rx_st_ff)
          async_serial_port_pkg::S_DATA: begin
            rx_shift_ff <= {rx_line, rx_shift_ff[7:1]};
            rx_par_ff   <= rx_par_ff ^ rx_line;
            rx_cnt_ff   <= rx_cnt_ff + 3'h1;
            if (rx_cnt_ff == rx_last) begin
              rx_st_ff <= line_ff.parity_enable ? async_serial_port_pkg::S_PAR
                                                : async_serial_port_pkg::S_STOP;
            end
          end
          async_serial_port_pkg::S_PAR: begin
            par_err  <= rx_par_ff ^ rx_line ^ ~line_ff.parity_sense;
            rx_st_ff <= async_serial_port_pkg::S_STOP;
          end
          async_serial_port_pkg::S_STOP: rx_st_ff <= async_serial_port_pkg::S_IDLE;
          default: rx_st_ff <= async_serial_port_pkg::S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_buf_ff <= 8'h00;
      unread_ff <= 1'b0;
    end else if (rx_done) begin
      rx_buf_ff <= rx_word;
      unread_ff <= 1'b1;
    end else if (rd & hit(paddr, async_serial_port_pkg::IDX_DATA)) begin
      unread_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Status flags
  always_comb begin
    nxt_status = status_ff;
    if (wr & hit(paddr, async_serial_port_pkg::IDX_STATUS)) begin
      nxt_status = status_ff & ~(wbyte & async_serial_port_pkg::ST_MASK);
    end
    if (tx_load) nxt_status[async_serial_port_pkg::ST_TXRDY] = 1'b1;
    if (rx_done) begin
      nxt_status[async_serial_port_pkg::ST_RXRDY] = 1'b1;
      if (par_err) nxt_status[async_serial_port_pkg::ST_PARITY_ERROR_FLAG] = 1'b1;
      if (unread_ff) nxt_status[async_serial_port_pkg::ST_OVERRUN_FLAG] = 1'b1;
      if (frm_err) nxt_status[async_serial_port_pkg::ST_FRAMING_ERROR_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_ff <= async_serial_port_pkg::RST_STATUS;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign rx_ready_irq = status_ff[async_serial_port_pkg::ST_RXRDY];
  assign tx_ready_irq = status_ff[async_serial_port_pkg::ST_TXRDY];

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_tx_load;
    tx_load;
  endsequence
  sequence s_start_low;
    (serial_out_pin == 1'b0) && (tx_st_ff == async_serial_port_pkg::S_START);
  endsequence

  property p_tx_start;
    s_tx_load |=> s_start_low ##1 (s_start_low [*8]);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit not low");

  property p_tx_ready;
    tx_load |=> tx_ready_irq && !tx_full_ff;
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("tx ready not set");

  property p_tx_par;
    (tx_st_ff == async_serial_port_pkg::S_PAR) |-> serial_out_pin == tx_par_ff;
  endproperty
  a_tx_par: assert property (p_tx_par) else $error("bad parity bit");

  property p_rx_buf;
    rx_done |=> rx_ready_irq && (rx_buf_ff == $past(rx_word)) && unread_ff;
  endproperty
  a_rx_buf: assert property (p_rx_buf) else $error("buffer not loaded");

  property p_len7;
    rx_done && line_ff.char_length_sel |=> rx_buf_ff[7] == 1'b0;
  endproperty
  a_len7: assert property (p_len7) else $error("seven bit length broken");

  property p_ovr;
    rx_done && unread_ff |=> status_ff[async_serial_port_pkg::ST_OVERRUN_FLAG];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun missed");

  property p_framing_error_flag;
    rx_done && !rx_line |=> status_ff[async_serial_port_pkg::ST_FRAMING_ERROR_FLAG];
  endproperty
  a_framing_error_flag: assert property (p_framing_error_flag) else $error("framing error missed");

  property p_w1c;
    $fell(status_ff[async_serial_port_pkg::ST_FRAMING_ERROR_FLAG]) |->
      $past(wr && hit(paddr, async_serial_port_pkg::IDX_STATUS)
            && pwdata[async_serial_port_pkg::ST_FRAMING_ERROR_FLAG]);
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag cleared without write");

  property p_rx_off;
    !line_ff.receive_enable && (rx_st_ff == async_serial_port_pkg::S_IDLE)
      |=> rx_st_ff == async_serial_port_pkg::S_IDLE;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver ran while off");

  property p_reload;
    ovf && !(wr && hit(paddr, async_serial_port_pkg::IDX_BCNT)) |=> bcnt_ff == $past(brld_ff);
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");

  property p_loop;
    test_ff.loopback_enable && !test_ff.force_parity_fault && !test_ff.force_framing_fault
      |-> rx_line == serial_out_pin;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback path broken");

endmodule : async_serial_port

// ===== pkg/async_serial_port_pkg.sv
// Constants, register map and field layouts of the asynchronous serial port.
package async_serial_port_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [27:0] IDX_DATA   = 28'h0600300;
  localparam logic [27:0] IDX_STATUS = 28'h0600301;
  localparam logic [27:0] IDX_LINE   = 28'h0600302;
  localparam logic [27:0] IDX_BAUDC  = 28'h0600303;
  localparam logic [27:0] IDX_BCNT   = 28'h0600304;
  localparam logic [27:0] IDX_BRLD   = 28'h0600305;
  localparam logic [27:0] IDX_TEST   = 28'h0600306;
  localparam int          DEC_LSB    = 2;
  localparam int          DEC_MSB    = 11;

  // ==========================================================================
  // Status bit positions
  localparam int ST_PARITY_ERROR_FLAG  = 0;
  localparam int ST_OVERRUN_FLAG  = 1;
  localparam int ST_FRAMING_ERROR_FLAG  = 2;
  localparam int ST_RXRDY = 4;
  localparam int ST_TXRDY = 5;
  localparam logic [7:0] ST_MASK = 8'h37;

  // ==========================================================================
  // Field layouts
  typedef struct packed {
    logic [2:0] rsv;
    logic       receive_enable;
    logic       tx_stop_count;
    logic       parity_sense;
    logic       parity_enable;
    logic       char_length_sel;
  } line_control_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic       baud_mode_select;
    logic       baud_overflow_flag;
    logic       baud_run;
    logic [1:0] baud_clock_select;
  } baud_control_t;

  typedef struct packed {
    logic [4:0] rsv;
    logic       force_framing_fault;
    logic       force_parity_fault;
    logic       loopback_enable;
  } test_control_t;

  localparam int BC_OVF = 3;

  // ==========================================================================
  // Reset values and timing counts
  localparam logic [7:0] RST_LINE   = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_BAUDC  = 8'h00;
  localparam logic [7:0] RST_BCNT   = 8'h00;
  localparam logic [7:0] RST_BRLD   = 8'h00;
  localparam logic [7:0] RST_TEST   = 8'h00;
  localparam logic [3:0] TICK_LAST  = 4'hf;
  localparam logic [3:0] TICK_MID   = 4'h7;
  localparam logic [2:0] LAST_BIT7  = 3'h6;
  localparam logic [2:0] LAST_BIT8  = 3'h7;

  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} serial_state_t;

endpackage : async_serial_port_pkg

// ===== verif/serial_remote.sv
// Remote serial transmitter and receiver facing the port.
`timescale 1ns/10ps
module serial_remote #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  int          flen = 12;
  logic [11:0] got [$];
  time         t_start [$];

  // ==========================================================================
  // Receiver: frames are captured at bit centres.
  initial begin : rx_side
    logic [11:0] f;
    forever begin
      @(negedge line_in);
      t_start.push_back($time);
      f = '1;
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < flen; i++) begin
        f[i] = line_in;
        if (i < flen - 1) repeat (BIT_CLKS) @(posedge clk);
      end
      got.push_back(f);
    end
  end

  // ==========================================================================
  // Transmitter: the line idles high between frames.
  initial line_out = 1'b1;

  task automatic send(input logic [11:0] f, input int len);
    for (int i = 0; i < len; i++) begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask : send
endmodule : serial_remote

// ===== verif/testbench.sv
// Self-checking bench for the asynchronous serial port.
`timescale 1ns/10ps
module testbench;
  localparam logic [27:0] B = async_serial_port_pkg::IDX_DATA;
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  logic        pready, pslverr, sin, sout, irq_rx, irq_tx, irq_bd;
  int          n_fail = 0, cmp_count = 0, cyc = 0, len, n0, gap;
  logic [11:0] rd, f;
  logic [7:0]  rows [4][2] = '{'{8'h10, 8'ha5}, '{8'h1b, 8'h3c},
                               '{8'h16, 8'hc3}, '{8'h1e, 8'h81}};

  always #12.5 clk = ~clk;

  async_serial_port uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(sin), .serial_out_pin(sout),
    .rx_ready_irq(irq_rx), .tx_ready_irq(irq_tx), .baud_tick_irq(irq_bd));

  serial_remote #(.BIT_CLKS(32)) r (.clk(clk), .line_in(sout), .line_out(sin));

  // ==========================================================================
  // Tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input int n, input logic [7:0] wd);
    int w = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, B + 28'(n), 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && w < 50) begin
      w++;
      @(posedge clk);
    end
    rd = {pslverr, 3'h0, prdata[7:0]};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wait_st(input int b);
    int k = 0;
    do begin
      apb(1'b0, 1, 8'h00);
      k++;
    end while (rd[b] !== 1'b1 && k < 400);
  endtask : wait_st

  function automatic logic [11:0] mk(input logic [7:0] c, input logic [7:0] d, output int n);
    logic [11:0] fr;
    logic        p;
    fr = '1;
    n = c[0] ? 7 : 8;
    p = ^d[6:0] ^ (c[0] ? 1'b0 : d[7]) ^ ~c[2];
    fr[0] = 1'b0;
    for (int i = 0; i < n; i++) fr[i + 1] = d[i];
    n = n + 1;
    if (c[1]) begin
      fr[n] = p;
      n = n + 1;
    end
    n = n + (c[3] ? 1 : 2);
    return fr;
  endfunction : mk

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 1; i < 7; i++) begin
      apb(1'b0, i, 8'h00);
      check("reset value", rd, 12'h000);
    end
    apb(1'b1, 5, 8'hff);
    apb(1'b1, 4, 8'hff);
    apb(1'b1, 3, 8'h14);
    f = mk(8'h00, 8'h55, len);
    r.send(f, len);
    apb(1'b0, 1, 8'h00);
    check("rx disabled", rd, 12'h000);
    check("baud irq", {11'h0, irq_bd}, 12'h001);
    foreach (rows[k]) begin
      apb(1'b1, 2, rows[k][0]);
      apb(1'b1, 1, 8'h37);
      f = mk(rows[k][0], rows[k][1], len);
      r.flen = len;
      n0 = r.got.size();
      apb(1'b1, 0, rows[k][1]);
      wait_st(5);
      check("tx ready", {11'h0, rd[5]}, 12'h001);
      apb(1'b1, 1, 8'h20);
      apb(1'b1, 0, ~rows[k][1]);
      for (int w = 0; w < 3000 && r.got.size() < n0 + 2; w++) @(posedge clk);
      check("frame", r.got[n0], f);
      check("frame 2", r.got[n0 + 1], mk(rows[k][0], ~rows[k][1], len));
      gap = int'((r.t_start[n0 + 1] - r.t_start[n0]) / 25) - len * 32;
      check("frame gap", {11'h0, gap == 0 || gap == 2}, 12'h001);
      r.send(f, len);
      wait_st(4);
      check("rx status", rd, 12'h030);
      check("irqs", {10'h0, irq_rx, irq_tx}, 12'h003);
      apb(1'b0, 0, 8'h00);
      check("rx data", rd, {4'h0, rows[k][0][0] ? 1'b0 : rows[k][1][7], rows[k][1][6:0]});
    end
    apb(1'b1, 2, 8'h16);
    apb(1'b1, 1, 8'h37);
    f = mk(8'h16, 8'h5a, len);
    f[9] = ~f[9];
    r.send(f, len);
    wait_st(4);
    f = mk(8'h16, 8'h69, len);
    f[10] = 1'b0;
    r.send(f, len);
    apb(1'b0, 1, 8'h00);
    check("error flags", rd, 12'h017);
    apb(1'b0, 0, 8'h00);
    check("overrun data", rd, 12'h069);
    apb(1'b1, 1, 8'h00);
    apb(1'b0, 1, 8'h00);
    check("write zero", rd, 12'h017);
    apb(1'b1, 1, 8'h05);
    apb(1'b0, 1, 8'h00);
    check("write one", rd, 12'h012);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 6, m ? 8'h05 : 8'h03);
      apb(1'b1, 1, 8'h37);
      apb(1'b1, 0, 8'h3c);
      wait_st(4);
      check("loop flags", rd & 12'h017, m ? 12'h014 : 12'h011);
      apb(1'b0, 0, 8'h00);
      check("loop data", rd, 12'h03c);
      repeat (80) @(posedge clk);
      check("pin frame", r.got[r.got.size() - 1], mk(8'h16, 8'h3c, len));
    end
    apb(1'b0, 7, 8'h00);
    check("unmapped", rd, 12'h800);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, 2, 8'h00);
    check("line reset", rd, 12'h000);
    report_and_stop();
  end
endmodule : testbench
